// ==== rtl/line_clock_supervisor.sv ====
// line clock supervisor: transmit clock watch, loss-of-signal pin, clock
// reference selection, driver high impedance, mode strap and interrupt
// assumes all inputs are synchronous to mclk_i and an AXI4-Lite master
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "line_clock_supervisor_map.svh"

module line_clock_supervisor #(
   parameter int ADDR_W     = `LCS_ADDR_W,
   parameter int MISS_LIMIT = `LCS_TX_MISS_LIMIT
) (
   input  wire logic                                mclk_i,
   input  wire logic                                srst_i,
   // line side
   input  wire logic                                tx_line_clock_i,
   input  wire logic                                los_det_i,
   input  wire logic                                mclk_lost_i,
   input  wire logic [1:0]                          mode_pins_i,
   output logic                                     signal_lost_out_o,
   output logic                                     tx_line_driver_pair_oe_o,
   output logic                                     rx_clk_from_mclk_o,
   output line_clock_supervisor_pkg::tx_sel_t       tx_sel_o,
   output line_clock_supervisor_pkg::ctrl_mode_t    ctrl_mode_o,
   output logic                                     tx_clk_missing_o,
   output logic                                     irq_o,
   // AXI4-Lite register port
   input  wire logic [ADDR_W-1:0]                   s_axi_awaddr_i,
   input  wire logic                                s_axi_awvalid_i,
   output logic                                     s_axi_awready_o,
   input  wire logic [31:0]                         s_axi_wdata_i,
   input  wire logic [3:0]                          s_axi_wstrb_i,
   input  wire logic                                s_axi_wvalid_i,
   output logic                                     s_axi_wready_o,
   output logic [1:0]                               s_axi_bresp_o,
   output logic                                     s_axi_bvalid_o,
   input  wire logic                                s_axi_bready_i,
   input  wire logic [ADDR_W-1:0]                   s_axi_araddr_i,
   input  wire logic                                s_axi_arvalid_i,
   output logic                                     s_axi_arready_o,
   output logic [31:0]                              s_axi_rdata_o,
   output logic [1:0]                               s_axi_rresp_o,
   output logic                                     s_axi_rvalid_o,
   input  wire logic                                s_axi_rready_i
);
   import line_clock_supervisor_pkg::*;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ctrl_t                 ctrl_q;
   logic [`LCS_INT_W-1:0] int_stat_q;
   logic [`LCS_INT_W-1:0] int_en_q;
   logic [`LCS_INT_W-1:0] int_set;
   logic [`LCS_INT_W-1:0] int_clr;
   logic                  los_q;
   logic                  miss_q;
   logic                  tx_miss;
   logic                  auto_ones_act;
   logic                  mode_done_q;
   ctrl_mode_t            mode_q;
   tx_sel_t               tx_sel_q;
   logic                  rx_ref_q;

   // decode of a word address, shared by the write and read paths
   function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(`LCS_OFS_CTRL)) begin
         return 3'h0;
      end else if (a == ADDR_W'(`LCS_OFS_STATUS)) begin
         return 3'h1;
      end else if (a == ADDR_W'(`LCS_OFS_INT_STAT)) begin
         return 3'h2;
      end else if (a == ADDR_W'(`LCS_OFS_INT_CLR)) begin
         return 3'h3;
      end else if (a == ADDR_W'(`LCS_OFS_INT_EN)) begin
         return 3'h4;
      end else begin
         return 3'h7;
      end
   endfunction

   tx_clock_watch #(
      .LIMIT           (MISS_LIMIT)
   ) u_watch (
      .mclk_i          (mclk_i),
      .srst_i          (srst_i),
      .tx_line_clock_i (tx_line_clock_i),
      .missing_o       (tx_miss)
   );

   // [RQ13] registered loss input
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         los_q  <= 1'b0;
         miss_q <= 1'b0;
      end else begin
         los_q  <= los_det_i;
         miss_q <= tx_miss;
      end
   end

   // [RQ2] active high pin
   // [RQ3] self clearing
   assign signal_lost_out_o = los_q;
   assign tx_clk_missing_o  = tx_miss;

   // [RQ4] driver released
   // left combinational: with the master clock gone no flop would update
   assign tx_line_driver_pair_oe_o = !mclk_lost_i;

   // [RQ9] mode strap capture
   // caught on the first edge after reset release, then frozen
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         mode_done_q <= 1'b0;
         mode_q      <= ctrl_mode_t'(`LCS_MODE_RST);
      end else if (!mode_done_q) begin
         mode_done_q <= 1'b1;
         mode_q      <= ctrl_mode_t'(mode_pins_i);
      end
   end
   assign ctrl_mode_o = mode_q;

   // [RQ5] receive clock source
   // [RQ11] gated by alarm enable
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rx_ref_q <= 1'b0;
      end else begin
         rx_ref_q <= los_det_i && ctrl_q.alarm_ind_enable;
      end
   end
   assign rx_clk_from_mclk_o = rx_ref_q;

   assign auto_ones_act = ctrl_q.auto_tx_all_ones && los_q;

   // [RQ8] forced master reference
   // [RQ7] patterns on master clock
   // alarm and automatic all-ones override whatever pattern software chose
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tx_sel_q <= '0;
      end else if (auto_ones_act || ctrl_q.ais_tx) begin
         tx_sel_q.ref_mclk <= 1'b1;
         tx_sel_q.pattern  <= PAT_ALL_ONES;
      end else begin
         tx_sel_q.ref_mclk <= ctrl_q.ref_mclk && (ctrl_q.pattern != PAT_DATA);
         tx_sel_q.pattern  <= ctrl_q.pattern;
      end
   end
   assign tx_sel_o = tx_sel_q;

   // write channel
   bus_state_t           wr_st_q;
   logic                 aw_have_q;
   logic                 w_have_q;
   logic [ADDR_W-1:0]    awaddr_q;
   logic [31:0]          wdata_q;
   logic [3:0]           wstrb_q;
   logic [1:0]           bresp_q;
   logic                 wr_fire;
   logic [2:0]           wr_sel;

   assign s_axi_awready_o = (wr_st_q == BUS_IDLE) && !aw_have_q;
   assign s_axi_wready_o  = (wr_st_q == BUS_IDLE) && !w_have_q;
   assign wr_fire         = (wr_st_q == BUS_IDLE) && aw_have_q && w_have_q;
   assign wr_sel          = decode(awaddr_q);

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         aw_have_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_have_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         w_have_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_have_q <= 1'b1;
         wdata_q  <= s_axi_wdata_i;
         wstrb_q  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wr_st_q <= BUS_IDLE;
         bresp_q <= RESP_OKAY;
      end else begin
         case (wr_st_q)
            BUS_IDLE: begin
               if (wr_fire) begin
                  wr_st_q <= BUS_RESP;
                  bresp_q <= (wr_sel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
               end
            end
            BUS_RESP: begin
               if (s_axi_bready_i) begin
                  wr_st_q <= BUS_IDLE;
               end
            end
            default: wr_st_q <= BUS_IDLE;
         endcase
      end
   end
   assign s_axi_bvalid_o = wr_st_q == BUS_RESP;
   assign s_axi_bresp_o  = bresp_q;

   // control and enable registers; all fields live in byte lane 0
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ctrl_q   <= ctrl_t'(`LCS_CTRL_RST);
         int_en_q <= `LCS_INT_RST;
      end else if (wr_fire && wstrb_q[0]) begin
         if (wr_sel == 3'h0) begin
            ctrl_q <= ctrl_t'(wdata_q[`LCS_CTRL_W-1:0]);
         end else if (wr_sel == 3'h4) begin
            int_en_q <= wdata_q[`LCS_INT_W-1:0];
         end
      end
   end

   assign int_clr = (wr_fire && wstrb_q[0] && wr_sel == 3'h3) ?
                    wdata_q[`LCS_INT_W-1:0] : '0;

   // [RQ10] sticky events
   // a set in the same cycle as its clear wins, so no event is dropped
   always_comb begin
      int_set                     = '0;
      int_set[`LCS_INT_TXMISS]    = tx_miss && !miss_q;
      int_set[`LCS_INT_LOS_SET]   = los_det_i && !los_q;
      int_set[`LCS_INT_LOS_CLR]   = !los_det_i && los_q;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         int_stat_q <= `LCS_INT_RST;
      end else begin
         int_stat_q <= (int_stat_q & ~int_clr) | int_set;
      end
   end
   assign irq_o = |(int_stat_q & int_en_q);

   // read channel
   bus_state_t  rd_st_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [31:0] rd_word;
   logic [2:0]  rd_sel;

   assign rd_sel          = decode(s_axi_araddr_i);
   assign s_axi_arready_o = rd_st_q == BUS_IDLE;

   always_comb begin
      rd_word = '0;
      case (rd_sel)
         3'h0: rd_word[`LCS_CTRL_W-1:0] = ctrl_q;
         3'h1: begin
            rd_word[`LCS_ST_TXMISS]    = tx_miss;
            rd_word[`LCS_ST_LOS]       = los_q;
            rd_word[`LCS_ST_MCLK_LOST] = mclk_lost_i;
            rd_word[`LCS_ST_MODE_LO]   = mode_q[0];
            rd_word[`LCS_ST_MODE_HI]   = mode_q[1];
            rd_word[`LCS_ST_RXREF]     = rx_ref_q;
            rd_word[`LCS_ST_TXREF]     = tx_sel_q.ref_mclk;
         end
         3'h2: rd_word[`LCS_INT_W-1:0] = int_stat_q;
         3'h4: rd_word[`LCS_INT_W-1:0] = int_en_q;
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rd_st_q <= BUS_IDLE;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         case (rd_st_q)
            BUS_IDLE: begin
               if (s_axi_arvalid_i) begin
                  rd_st_q <= BUS_RESP;
                  rdata_q <= rd_word;
                  rresp_q <= (rd_sel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
               end
            end
            BUS_RESP: begin
               if (s_axi_rready_i) begin
                  rd_st_q <= BUS_IDLE;
               end
            end
            default: rd_st_q <= BUS_IDLE;
         endcase
      end
   end
   assign s_axi_rvalid_o = rd_st_q == BUS_RESP;
   assign s_axi_rdata_o  = rdata_q;
   assign s_axi_rresp_o  = rresp_q;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   sequence s_los_rise;
      !los_det_i ##1 los_det_i;
   endsequence
   sequence s_los_fall;
      los_det_i ##1 !los_det_i;
   endsequence

   a_los_raise_pin: assert property ( // [RQ2]
      s_los_rise |=> signal_lost_out_o)
      else $error("loss pin did not rise one cycle after detection");
   a_los_self_clear: assert property ( // [RQ3]
      s_los_fall |=> !signal_lost_out_o && int_stat_q[`LCS_INT_LOS_CLR])
      else $error("loss pin did not clear by itself");
   a_los_registered: assert property ( // [RQ13]
      ##1 signal_lost_out_o == $past(los_det_i))
      else $error("loss pin not the registered detector input");
   a_driver_hiz: assert property ( // [RQ4]
      mclk_lost_i |-> !tx_line_driver_pair_oe_o)
      else $error("line driver enabled while master clock lost");
   a_rx_ref_los: assert property ( // [RQ11]
      (los_det_i && ctrl_q.alarm_ind_enable) |=> rx_clk_from_mclk_o)
      else $error("receive clock not from master clock during loss");
   a_rx_ref_off: assert property ( // [RQ5]
      !los_det_i |=> !rx_clk_from_mclk_o)
      else $error("receive clock on master clock without loss");
   a_alarm_ref: assert property ( // [RQ8]
      (auto_ones_act || ctrl_q.ais_tx) |=>
         tx_sel_o.ref_mclk && tx_sel_o.pattern == PAT_ALL_ONES)
      else $error("alarm all-ones not on master clock reference");
   a_pattern_ref: assert property ( // [RQ7]
      (ctrl_q.ref_mclk && ctrl_q.pattern != PAT_DATA) |=> tx_sel_o.ref_mclk)
      else $error("test pattern not on master clock reference");
   a_mode_frozen: assert property ( // [RQ9]
      mode_done_q ##1 mode_done_q |-> $stable(ctrl_mode_o))
      else $error("control mode changed after strap capture");
   a_miss_irq: assert property ( // [RQ10]
      (tx_miss && !miss_q && int_en_q[`LCS_INT_TXMISS]) |=>
         irq_o && int_stat_q[`LCS_INT_TXMISS])
      else $error("unmasked transmit clock missing did not interrupt");

endmodule // line_clock_supervisor
`default_nettype wire

// ==== rtl/line_clock_supervisor_map.svh ====
// register offsets, field positions, reset values and counts of the clock supervisor
// assumes a 32-bit AXI4-Lite register port and a 100 MHz master clock
//
// Functional notes
// [RQ1] flag transmit clock missing after more than 70 stable master clock cycles
// [RQ2] loss-of-signal output is active high while the line signal is lost
// [RQ3] loss-of-signal output falls by itself once valid signal returns
// [RQ4] line driver pair goes high impedance when the master clock is lost
// [RQ5] during loss of signal the receive clock comes from the master clock; the code does this only while alarm_ind_enable is 1
// [RQ6] system supplies the master clock at the selected rate, 2.048MHz for E1
// [RQ7] master clock as reference clocks out all-ones, all-zeros and PRBS patterns
// [RQ8] automatic all-ones and alarm indication always use the master clock
// [RQ9] control interface mode follows the two sampled mode-select pins
// [RQ10] unmasked transmit clock missing event raises the host interrupt
// [RQ11] receive clock from master clock while signal lost and alarm enable is 1
// [RQ12] activity counter restarts on each edge; missing clears on first edge
// [RQ13] loss decision arrives as one synchronous input, registered before the pin
`ifndef LINE_CLOCK_SUPERVISOR_MAP_SVH
`define LINE_CLOCK_SUPERVISOR_MAP_SVH

`define LCS_ADDR_W        5
`define LCS_OFS_CTRL      5'h00
`define LCS_OFS_STATUS    5'h04
`define LCS_OFS_INT_STAT  5'h08
`define LCS_OFS_INT_CLR   5'h0c
`define LCS_OFS_INT_EN    5'h10

`define LCS_CTRL_W        6
`define LCS_CTRL_RST      6'h00
`define LCS_INT_W         3
`define LCS_INT_RST       3'h0
`define LCS_INT_TXMISS    0
`define LCS_INT_LOS_SET   1
`define LCS_INT_LOS_CLR   2

`define LCS_ST_TXMISS     0
`define LCS_ST_LOS        1
`define LCS_ST_MCLK_LOST  2
`define LCS_ST_MODE_LO    3
`define LCS_ST_MODE_HI    4
`define LCS_ST_RXREF      5
`define LCS_ST_TXREF      6

`define LCS_TX_MISS_LIMIT 70
`define LCS_MODE_RST      2'h0

`endif

// ==== rtl/line_clock_supervisor_pkg.sv ====
// types shared by the clock supervisor and its testbench
// assumes the constants header is included by the users as well
package line_clock_supervisor_pkg;

   typedef enum logic [1:0] {
      PAT_DATA      = 2'b00,
      PAT_ALL_ONES  = 2'b01,
      PAT_ALL_ZEROS = 2'b10,
      PAT_PRBS      = 2'b11
   } tx_pat_t;

   typedef enum logic [1:0] {
      MODE_HARDWARE = 2'b00,
      MODE_SERIAL   = 2'b01,
      MODE_PAR_MUXA = 2'b10,
      MODE_PAR_MUXB = 2'b11
   } ctrl_mode_t;

   // software control word, 6 bits, low byte of the control register
   typedef struct packed {
      logic    ais_tx;
      logic    auto_tx_all_ones;
      tx_pat_t pattern;
      logic    alarm_ind_enable;
      logic    ref_mclk;
   } ctrl_t;

   // what the transmit side is told to do
   typedef struct packed {
      logic    ref_mclk;
      tx_pat_t pattern;
   } tx_sel_t;

   typedef enum logic [1:0] {
      REG_CTRL     = 2'b00,
      REG_STATUS   = 2'b01,
      REG_INT      = 2'b10,
      REG_NONE     = 2'b11
   } reg_grp_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_RESP = 1'b1
   } bus_state_t;

endpackage

// ==== rtl/tx_clock_watch.sv ====
// watches the sampled transmit clock for activity against the master clock
// assumes tx_line_clock_i is already synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
`include "line_clock_supervisor_map.svh"

module tx_clock_watch #(
   parameter int LIMIT = `LCS_TX_MISS_LIMIT
) (
   input  wire logic mclk_i,
   input  wire logic srst_i,
   input  wire logic tx_line_clock_i,
   output logic      missing_o
);
   localparam int CW = $clog2(LIMIT + 1);

   logic          prev_q;
   logic [CW-1:0] cnt_q;
   logic          edge_seen;

   assign edge_seen = tx_line_clock_i != prev_q;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= tx_line_clock_i;
      end
   end

   // [RQ12] restart on edges
   always_ff @(posedge mclk_i) begin
      if (srst_i || edge_seen) begin
         cnt_q <= '0;
      end else if (cnt_q != CW'(LIMIT)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // [RQ1] stable past limit
   always_ff @(posedge mclk_i) begin
      if (srst_i || edge_seen) begin
         missing_o <= 1'b0;
      end else if (cnt_q == CW'(LIMIT)) begin
         missing_o <= 1'b1;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   a_miss_after_limit: assert property ( // [RQ1]
      (cnt_q == CW'(LIMIT)) && !edge_seen |=> missing_o)
      else $error("transmit clock missing not flagged after limit");
   a_miss_not_early: assert property ( // [RQ1]
      $rose(missing_o) |-> $past(cnt_q) == CW'(LIMIT))
      else $error("transmit clock missing flagged too early");
   a_edge_restart: assert property ( // [RQ12]
      edge_seen |=> (cnt_q == '0) && !missing_o)
      else $error("edge did not restart the activity count");

endmodule // tx_clock_watch
`default_nettype wire

// ==== testbench/framer_model.sv ====
// model of the framer side: transmit line clock and loss-of-signal decision
// assumes one master clock; outputs change just after its rising edge
`timescale 1ns/1ps
`default_nettype none

module framer_model (
   input  wire logic mclk_i,
   input  wire logic srst_i,
   input  wire logic run_i,
   input  wire logic los_i,
   output logic      tx_line_clock_o,
   output logic      los_det_o
);
   // clock may stall
   // a stalled clock holds its last level, the exact case the watch must catch
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tx_line_clock_o <= 1'b0;
      end else if (run_i) begin
         tx_line_clock_o <= ~tx_line_clock_o;
      end
   end

   always_ff @(posedge mclk_i) begin
      los_det_o <= los_i & ~srst_i;
   end
endmodule // framer_model

`default_nettype wire

// ==== testbench/test_line_clock_supervisor.sv ====
// self-checking bench of the line clock supervisor, registers over AXI4-Lite
// assumes the framer model on the line side and a 100 MHz master clock
`timescale 1ns/1ps
`default_nettype none
`include "line_clock_supervisor_map.svh"

`define check_eq(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module test_line_clock_supervisor;
   import line_clock_supervisor_pkg::*;
   localparam int LIM = 5;
   logic        mclk      = 1'b0;
   logic        srst      = 1'b1;
   logic        run       = 1'b1;
   logic        signal_lost_out       = 1'b0;
   logic        mclk_lost = 1'b0;
   logic [1:0]  mode_pins = 2'b10;
   logic        tx_clk, los_det, sig_lost, oe, rx_mclk, tx_miss, irq;
   tx_sel_t     tx_sel;
   ctrl_mode_t  mode;
   logic [4:0]  awaddr = '0;
   logic [4:0]  araddr = '0;
   logic [31:0] wdata  = '0;
   logic [3:0]  wstrb  = '0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rdat;
   logic [31:0] lc [2] = '{32'h12, 32'h00};
   int          n_mismatch = 0;
   int          n_compared = 0;

   always #5 mclk = ~mclk;

   framer_model u_framer (.mclk_i(mclk), .srst_i(srst), .run_i(run), .los_i(signal_lost_out),
      .tx_line_clock_o(tx_clk), .los_det_o(los_det));

   line_clock_supervisor #(.MISS_LIMIT(LIM)) u_dut (
      .mclk_i(mclk), .srst_i(srst), .tx_line_clock_i(tx_clk), .los_det_i(los_det),
      .mclk_lost_i(mclk_lost), .mode_pins_i(mode_pins), .signal_lost_out_o(sig_lost),
      .tx_line_driver_pair_oe_o(oe), .rx_clk_from_mclk_o(rx_mclk), .tx_sel_o(tx_sel),
      .ctrl_mode_o(mode), .tx_clk_missing_o(tx_miss), .irq_o(irq),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

   // address and data offered together, each released on its own handshake
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      bit ad, wd, done;
      ad = 0;
      wd = 0;
      done = 0;
      r = 2'bxx;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (ad && wd && bvalid) begin
            r = bresp;
            done = 1;
            bready <= 1'b0;
         end
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
   endtask

   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ad, done;
      ad = 0;
      done = 0;
      d = 'x;
      r = 2'bxx;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (ad && rvalid) begin
            d = rdata;
            r = rresp;
            done = 1;
            rready <= 1'b0;
         end
         if (!ad && arready) begin
            ad = 1;
            arvalid <= 1'b0;
         end
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      `check_eq("mode", MODE_PAR_MUXA, mode)
      @(posedge mclk);
      mode_pins <= 2'b01;
      repeat (2) @(posedge mclk);
      #1;
      `check_eq("mode held", MODE_PAR_MUXA, mode)
      axi_rd(`LCS_OFS_CTRL, rdat, resp);
      `check_eq("ctrl reset", 32'h0, rdat)
      axi_rd(`LCS_OFS_STATUS, rdat, resp);
      `check_eq("status", 32'h10, rdat)
      axi_rd(5'h14, rdat, resp);
      `check_eq("unmapped rresp", 2'h2, resp)
      axi_wr(5'h14, 32'hff, resp);
      `check_eq("unmapped bresp", 2'h2, resp)
      for (int p = 0; p < 4; p++) begin
         axi_wr(`LCS_OFS_CTRL, 32'((p << 2) | 1), resp);
         repeat (2) @(posedge mclk);
         #1;
         `check_eq("pattern", tx_pat_t'(p[1:0]), tx_sel.pattern)
         axi_rd(`LCS_OFS_STATUS, rdat, resp);
         `check_eq("tx ref", (p != 0), rdat[6])
      end
      axi_wr(`LCS_OFS_CTRL, 32'h20, resp);
      repeat (2) @(posedge mclk);
      #1;
      `check_eq("ais sel", tx_sel_t'{1'b1, PAT_ALL_ONES}, tx_sel)
      foreach (lc[i]) begin
         axi_wr(`LCS_OFS_CTRL, lc[i], resp);
         @(posedge mclk);
         signal_lost_out <= 1'b1;
         repeat (2) @(posedge mclk);
         #1;
         `check_eq("los out", 1'b1, sig_lost)
         `check_eq("rx ref", lc[i][1], rx_mclk)
         @(posedge mclk);
         #1;
         `check_eq("auto sel", lc[i][4] ? tx_sel_t'{1'b1, PAT_ALL_ONES} : 3'h0, tx_sel)
         @(posedge mclk);
         signal_lost_out <= 1'b0;
         repeat (2) @(posedge mclk);
         #1;
         `check_eq("los off", 1'b0, sig_lost)
         `check_eq("rx ref off", 1'b0, rx_mclk)
      end
      axi_rd(`LCS_OFS_INT_STAT, rdat, resp);
      `check_eq("los events", 32'h6, rdat)
      axi_wr(`LCS_OFS_INT_CLR, 32'h7, resp);
      axi_wr(`LCS_OFS_INT_EN, 32'h1, resp);
      for (int m = 1; m >= 0; m--) begin
         @(posedge mclk);
         run <= 1'b0;
         // level held exactly the limit: not yet missing, one cycle more: missing
         repeat (LIM + 1) @(posedge mclk);
         #1;
         `check_eq("miss early", 1'b0, tx_miss)
         @(posedge mclk);
         #1;
         `check_eq("miss", 1'b1, tx_miss)
         repeat (2) @(posedge mclk);
         #1;
         `check_eq("irq", m[0], irq)
         @(posedge mclk);
         run <= 1'b1;
         repeat (4) @(posedge mclk);
         #1;
         `check_eq("miss clear", 1'b0, tx_miss)
         axi_rd(`LCS_OFS_INT_STAT, rdat, resp);
         `check_eq("int stat", 32'h1, rdat)
         axi_wr(`LCS_OFS_INT_CLR, 32'h1, resp);
         @(posedge mclk);
         #1;
         `check_eq("irq clear", 1'b0, irq)
         axi_wr(`LCS_OFS_INT_EN, 32'h0, resp);
      end
      @(posedge mclk);
      mclk_lost <= 1'b1;
      #1;
      `check_eq("driver off", 1'b0, oe)
      axi_rd(`LCS_OFS_STATUS, rdat, resp);
      `check_eq("status lost", 32'h14, rdat)
      @(posedge mclk);
      mclk_lost <= 1'b0;
      #1;
      `check_eq("driver on", 1'b1, oe)
      print_verdict();
   end

   // the tests need well under two thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      print_verdict();
   end
endmodule // test_line_clock_supervisor

`default_nettype wire
